// File: inc/bcd_pkg.sv
package bcd_pkg;

	localparam int BCD_DW = 32;
	localparam int BCD_AW = 4;

	typedef enum logic [2:0] {
		bit_test_op = 3'h0,
		short_bit_test_op = 3'h1,
		bit_toggle_op = 3'h2,
		compare_op = 3'h3,
		short_compare_op = 3'h4,
		division_step_op = 3'h5
	} bcd_op_t;

	// write channel states
	typedef enum logic [1:0] {
		BCD_W_IDLE = 2'b01,
		BCD_W_RESP = 2'b10
	} bcd_wst_t;

	localparam logic [BCD_AW-1:0] BCD_FLAGS_OFF = 4'h0;
	localparam logic [BCD_AW-1:0] BCD_STEP_OFF = 4'h4;
	localparam logic [BCD_AW-1:0] BCD_LAST_OFF = 4'h8;

	localparam int BCD_Z_BIT = 0;
	localparam int BCD_N_BIT = 1;
	localparam int BCD_C_BIT = 2;
	localparam int BCD_V_BIT = 3;
	localparam int BCD_S_BIT = 4;
	localparam int BCD_NFLAGS = 5;
	localparam int BCD_DONE_BIT = 8;

	localparam logic [BCD_NFLAGS-1:0] BCD_FLAGS_RST = 5'h00;
	localparam logic [BCD_DW-1:0] BCD_LAST_RST = 32'h0000_0000;
	localparam logic [4:0] BCD_CNT_RST = 5'h00;
	localparam logic [4:0] BCD_DIV_STEPS = 5'h0f;
	localparam logic [4:0] BCD_CNT_MAX = 5'h1f;
	localparam logic [4:0] BCD_BITSEL_MASK = 5'h1f;

	localparam logic [1:0] BCD_RESP_OKAY = 2'h0;
	localparam logic [1:0] BCD_RESP_SLVERR = 2'h2;

endpackage

// File: design/bcd_exec.sv
module bcd_exec
	import bcd_pkg::*;
(
	input bcd_op_t op,
	input logic [BCD_DW-1:0] src1,
	input logic [BCD_DW-1:0] src2,
	output logic [BCD_DW-1:0] result,
	output logic res_z,
	output logic res_n,
	output logic res_c,
	output logic res_v
);

	logic [BCD_DW-1:0] mask;
	logic [BCD_DW:0] diff;
	logic [BCD_DW-1:0] shifted;
	logic [BCD_DW-1:0] step_sub;

	always_comb begin
		mask = 32'h0000_0001 << (src2[4:0] & BCD_BITSEL_MASK); // RL3 RL4
		diff = {1'b0, src1} - {1'b0, src2};
		shifted = {src1[BCD_DW-2:0], 1'b0};
		step_sub = shifted - src2;
		res_c = 1'b0;
		res_v = 1'b0;
		case (op)
			bit_test_op, short_bit_test_op: begin
				result = src1 & mask; // RL3
			end
			bit_toggle_op: begin
				result = src1 ^ mask; // RL4
			end
			compare_op, short_compare_op: begin
				result = diff[BCD_DW-1:0]; // RL6
				res_c = diff[BCD_DW]; // RL7
				res_v = (src1[BCD_DW-1] ^ src2[BCD_DW-1]) & (src1[BCD_DW-1] ^ diff[BCD_DW-1]); // RL7
			end
			division_step_op: begin
				if (src1 == 32'h0000_0000) begin
					result = 32'h0000_0000; // RL10
				end else if (shifted >= src2) begin
					result = step_sub | 32'h0000_0001; // RL11
				end else begin
					result = shifted; // RL11
				end
			end
			default: begin
				result = 32'h0000_0000;
			end
		endcase
		res_z = (result == 32'h0000_0000);
		res_n = result[BCD_DW-1];
	end

endmodule

// File: design/bcd_alu.sv
// Functional notes
// RL1 - bit test never writes a destination
// RL2 - both bit test forms always update flags
// RL3 - bit test masks bit src2&31; sets Z,N
// RL4 - toggle inverts bit src2[4:0], writes destination
// RL5 - toggle flags only with flag-set; C,V kept
// RL6 - compare subtracts, updates flags, discards difference
// RL7 - compare sets Z, N, carry, overflow
// RL8 - compare always treated as flag-setting
// RL9 - both compare forms always update flags
// RL10 - division step gives zero for zero src1
// RL11 - shift, conditional subtract, set bit zero
// RL12 - division step leaves all flags unchanged
// RL13 - software issues fifteen consecutive division steps
// RL14 - software supplies valid positive operands
// RL15 - equal operands give 0x00007FFF after sequence
// RL16 - quotient low half, remainder high half
// RL17 - software pre-shifts by 15, masks result
// RL18 - false condition leaves destination, flags unchanged
module bcd_alu
	import bcd_pkg::*;
(
	input logic aclk,
	input logic aresetn,
	input logic [BCD_AW-1:0] s_axi_awaddr,
	input logic s_axi_awvalid,
	output logic s_axi_awready,
	input logic [BCD_DW-1:0] s_axi_wdata,
	input logic [3:0] s_axi_wstrb,
	input logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [BCD_AW-1:0] s_axi_araddr,
	input logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [BCD_DW-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic op_valid,
	input bcd_op_t op_code,
	input logic cond_true,
	input logic flag_set,
	input logic [BCD_DW-1:0] src1,
	input logic [BCD_DW-1:0] src2,
	output logic wb_valid,
	output logic wb_wr_en,
	output logic [BCD_DW-1:0] wb_data,
	output logic flag_z,
	output logic flag_n,
	output logic flag_c,
	output logic flag_v,
	output logic flag_s
);

	function automatic logic is_test(input bcd_op_t op);
		is_test = (op == bit_test_op) || (op == short_bit_test_op);
	endfunction

	function automatic logic is_cmp(input bcd_op_t op);
		is_cmp = (op == compare_op) || (op == short_compare_op);
	endfunction

	function automatic logic writes_dest(input bcd_op_t op);
		writes_dest = (op == bit_toggle_op) || (op == division_step_op);
	endfunction

	logic [BCD_DW-1:0] ex_result;
	logic ex_z;
	logic ex_n;
	logic ex_c;
	logic ex_v;
	logic exec;
	logic upd_zn;
	logic upd_cv;

	logic [BCD_NFLAGS-1:0] flags_r;
	logic [BCD_DW-1:0] wb_data_r;
	logic wb_valid_r;
	logic wb_wr_en_r;
	logic [BCD_DW-1:0] last_r;
	logic [4:0] div_cnt_r;

	bcd_wst_t wst_r;
	logic aw_got_r;
	logic w_got_r;
	logic [BCD_AW-1:0] aw_addr_r;
	logic [BCD_DW-1:0] w_data_r;
	logic [3:0] w_strb_r;
	logic [1:0] bresp_r;
	logic [BCD_DW-1:0] rdata_r;
	logic [1:0] rresp_r;
	logic rvalid_r;
	logic do_write;
	logic flag_wr;
	logic aw_take;
	logic w_take;
	logic ar_take;

	bcd_exec bcd_exec_i (
		.op(op_code),
		.src1(src1),
		.src2(src2),
		.result(ex_result),
		.res_z(ex_z),
		.res_n(ex_n),
		.res_c(ex_c),
		.res_v(ex_v)
	);

	// false condition executes nothing
	assign exec = op_valid & cond_true; // RL18
	// test and compare ignore the suffix; toggle honours it; division step never
	assign upd_zn = exec & (is_test(op_code) | is_cmp(op_code)
		| ((op_code == bit_toggle_op) & flag_set)); // RL2 RL5 RL8 RL9 RL12
	assign upd_cv = exec & is_cmp(op_code); // RL7 RL5

	// write-back stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wb_valid_r <= 1'b0;
			wb_wr_en_r <= 1'b0;
			wb_data_r <= BCD_LAST_RST;
		end else begin
			wb_valid_r <= op_valid;
			wb_wr_en_r <= exec & writes_dest(op_code); // RL1 RL4 RL6 RL18
			if (exec & writes_dest(op_code)) begin
				wb_data_r <= ex_result; // RL4 RL11 RL15 RL16
			end
		end
	end

	// status flags; an executing instruction's Z,N,C,V update wins over a register write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_r <= BCD_FLAGS_RST;
		end else begin
			if (flag_wr) begin
				flags_r <= w_data_r[BCD_NFLAGS-1:0];
			end
			if (upd_zn) begin
				flags_r[BCD_Z_BIT] <= ex_z; // RL3 RL5 RL7
				flags_r[BCD_N_BIT] <= ex_n; // RL3 RL5 RL7
			end
			if (upd_cv) begin
				flags_r[BCD_C_BIT] <= ex_c; // RL7
				flags_r[BCD_V_BIT] <= ex_v; // RL7
			end
		end
	end

	// consecutive division step count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt_r <= BCD_CNT_RST;
			last_r <= BCD_LAST_RST;
		end else if (exec) begin
			if (op_code == division_step_op) begin
				if (div_cnt_r != BCD_CNT_MAX) begin
					div_cnt_r <= div_cnt_r + 5'h01;
				end
			end else begin
				div_cnt_r <= BCD_CNT_RST;
			end
			if (writes_dest(op_code)) begin
				last_r <= ex_result;
			end
		end
	end

	assign wb_valid = wb_valid_r;
	assign wb_wr_en = wb_wr_en_r;
	assign wb_data = wb_data_r;
	assign flag_z = flags_r[BCD_Z_BIT];
	assign flag_n = flags_r[BCD_N_BIT];
	assign flag_c = flags_r[BCD_C_BIT];
	assign flag_v = flags_r[BCD_V_BIT];
	assign flag_s = flags_r[BCD_S_BIT];

	// register bus: write path
	assign s_axi_awready = (wst_r == BCD_W_IDLE) & !aw_got_r;
	assign s_axi_wready = (wst_r == BCD_W_IDLE) & !w_got_r;
	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take = s_axi_wvalid & s_axi_wready;
	assign do_write = (wst_r == BCD_W_IDLE) & aw_got_r & w_got_r;
	assign flag_wr = do_write & (aw_addr_r[BCD_AW-1:2] == BCD_FLAGS_OFF[BCD_AW-1:2]) & w_strb_r[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			aw_addr_r <= BCD_FLAGS_OFF;
		end else if (aw_take) begin
			aw_got_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (do_write) begin
			aw_got_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got_r <= 1'b0;
			w_data_r <= BCD_LAST_RST;
			w_strb_r <= 4'h0;
		end else if (w_take) begin
			w_got_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (do_write) begin
			w_got_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wst_r <= BCD_W_IDLE;
			bresp_r <= BCD_RESP_OKAY;
		end else begin
			case (wst_r)
				BCD_W_IDLE: begin
					if (do_write) begin
						wst_r <= BCD_W_RESP;
						if (aw_addr_r[BCD_AW-1:2] == BCD_FLAGS_OFF[BCD_AW-1:2]) begin
							bresp_r <= BCD_RESP_OKAY;
						end else begin
							bresp_r <= BCD_RESP_SLVERR;
						end
					end
				end
				BCD_W_RESP: begin
					if (s_axi_bready) begin
						wst_r <= BCD_W_IDLE;
					end
				end
				default: begin
					wst_r <= BCD_W_IDLE;
				end
			endcase
		end
	end

	assign s_axi_bvalid = (wst_r == BCD_W_RESP);
	assign s_axi_bresp = bresp_r;

	// register bus: read path
	assign s_axi_arready = !rvalid_r;
	assign ar_take = s_axi_arvalid & s_axi_arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= BCD_LAST_RST;
			rresp_r <= BCD_RESP_OKAY;
		end else if (ar_take) begin
			rvalid_r <= 1'b1;
			rresp_r <= BCD_RESP_OKAY;
			case (s_axi_araddr[BCD_AW-1:2])
				BCD_FLAGS_OFF[BCD_AW-1:2]: begin
					rdata_r <= {27'h0, flags_r};
				end
				BCD_STEP_OFF[BCD_AW-1:2]: begin
					rdata_r <= {27'h0, div_cnt_r};
					rdata_r[BCD_DONE_BIT] <= (div_cnt_r == BCD_DIV_STEPS);
				end
				BCD_LAST_OFF[BCD_AW-1:2]: begin
					rdata_r <= last_r; // RL16
				end
				default: begin
					rdata_r <= 32'h0000_0000;
					rresp_r <= BCD_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// checks
	logic [BCD_DW-1:0] chk_mask;
	logic [BCD_DW:0] chk_diff;
	assign chk_mask = 32'h0000_0001 << src2[4:0];
	assign chk_diff = {1'b0, src1} - {1'b0, src2};

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_test_no_write: assert property (exec & is_test(op_code) |=> !wb_wr_en) // RL1
		else $error("bit test wrote a destination");
	a_test_flags: assert property (exec & is_test(op_code) & !flag_wr // RL3
		|=> flag_z == (($past(src1) & $past(chk_mask)) == 32'h0) && flag_n == $past(src1[31] & chk_mask[31]))
		else $error("bit test flags wrong");
	a_test_always: assert property (exec & is_test(op_code) & !flag_set // RL2
		|=> flag_z == (($past(src1) & $past(chk_mask)) == 32'h0))
		else $error("bit test skipped flag update");
	a_test_cv: assert property (exec & is_test(op_code) & !flag_wr // RL3
		|=> $stable(flag_c) && $stable(flag_v))
		else $error("bit test changed carry or overflow");
	a_toggle_data: assert property (exec & (op_code == bit_toggle_op) // RL4
		|=> wb_wr_en && wb_data == ($past(src1) ^ $past(chk_mask)))
		else $error("toggle result wrong");
	a_toggle_noflag: assert property (exec & (op_code == bit_toggle_op) & !flag_set & !flag_wr // RL5
		|=> $stable(flags_r))
		else $error("toggle changed flags without suffix");
	a_toggle_cv: assert property (exec & (op_code == bit_toggle_op) & !flag_wr // RL5
		|=> $stable(flag_c) && $stable(flag_v))
		else $error("toggle changed carry or overflow");
	a_toggle_flags: assert property (exec & (op_code == bit_toggle_op) & flag_set // RL5
		|=> flag_z == (wb_data == 32'h0) && flag_n == wb_data[31])
		else $error("toggle flags wrong");
	a_cmp_nowrite: assert property (exec & is_cmp(op_code) |=> !wb_wr_en) // RL6
		else $error("compare wrote a destination");
	a_cmp_flags: assert property (exec & is_cmp(op_code) & !flag_set // RL7 RL8 RL9
		|=> flag_c == $past(chk_diff[32]) && flag_z == ($past(src1) == $past(src2)))
		else $error("compare flags wrong");
	a_cmp_nv: assert property (exec & is_cmp(op_code) // RL7
		|=> flag_n == $past(chk_diff[31])
		&& flag_v == $past((src1[31] ^ src2[31]) & (src1[31] ^ chk_diff[31])))
		else $error("compare sign or overflow flag wrong");
	a_div_zero: assert property (exec & (op_code == division_step_op) & (src1 == 32'h0) // RL10
		|=> wb_wr_en && wb_data == 32'h0)
		else $error("division step of zero not zero");
	a_div_lsb: assert property (exec & (op_code == division_step_op) & (src1 != 32'h0) // RL11
		|=> wb_data[0] == ($past({src1[30:0], 1'b0}) >= $past(src2)))
		else $error("division step quotient bit wrong");
	a_div_sub: assert property (exec & (op_code == division_step_op) & (src1 != 32'h0) // RL11
		& ({src1[30:0], 1'b0} >= src2) |=> wb_data == ($past({src1[30:0], 1'b0} - src2) | 32'h0000_0001))
		else $error("division step subtract result wrong");
	a_div_shift: assert property (exec & (op_code == division_step_op) & (src1 != 32'h0) // RL11
		& ({src1[30:0], 1'b0} < src2) |=> wb_data == $past({src1[30:0], 1'b0}))
		else $error("division step shift result wrong");
	a_div_flags: assert property (exec & (op_code == division_step_op) & !flag_wr // RL12
		|=> $stable(flags_r))
		else $error("division step changed flags");
	a_cond_false: assert property (op_valid & !cond_true & !flag_wr // RL18
		|=> !wb_wr_en && $stable(flags_r) && $stable(wb_data))
		else $error("false condition had an effect");

	c_compare: cover property (exec & is_cmp(op_code) ##1 flag_v);
	c_div_seq: cover property (div_cnt_r == BCD_DIV_STEPS);
	c_toggle_flags: cover property (exec & (op_code == bit_toggle_op) & flag_set);
	c_bus_write: cover property (flag_wr);
	c_cond_false: cover property (op_valid & !cond_true);

endmodule

// File: test/bcd_pipe.sv
module bcd_pipe
	import bcd_pkg::*;
(
	input wire logic aclk,
	output logic op_valid,
	output bcd_op_t op_code,
	output logic cond_true,
	output logic flag_set,
	output logic [BCD_DW-1:0] src1,
	output logic [BCD_DW-1:0] src2,
	input wire logic [BCD_DW-1:0] wb_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		op_valid = 1'b0;
		op_code = bit_test_op;
		cond_true = 1'b0;
		flag_set = 1'b0;
		src1 = '0;
		src2 = '0;
	end
	// released operands show the inverse of the last value
	task automatic issue(input bcd_op_t op, input logic cc, input logic f, input logic [31:0] a, input logic [31:0] b);
		@(posedge aclk);
		op_valid <= 1'b1;
		op_code <= op;
		cond_true <= cc;
		flag_set <= f;
		src1 <= a;
		src2 <= b;
		@(posedge aclk);
		op_valid <= 1'b0;
		src1 <= ~a;
		src2 <= ~b;
		#1;
	endtask
	// positive operands, den not below num
	task automatic div_seq(input logic [15:0] num, input logic [15:0] den);
		logic [31:0] acc;
		acc = {16'h0000, num} << 15;
		for (int i = 0; i < 15; i++) begin
			issue(division_step_op, 1'b1, 1'b0, acc, {16'h0000, den} << 15);
			acc = wb_data;
		end
	endtask
endmodule

// File: test/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import bcd_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [BCD_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [BCD_DW-1:0] s_axi_wdata = '0, s_axi_rdata, wb_data, src1, src2;
	logic [3:0] s_axi_wstrb = '0;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic op_valid, cond_true, flag_set, wb_valid, wb_wr_en, flag_z, flag_n, flag_c, flag_v, flag_s;
	bcd_op_t op_code;
	int n_fail = 0;
	int samples_checked = 0;
	always #25 aclk = ~aclk;
	bcd_alu bcd_alu_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.op_valid(op_valid), .op_code(op_code), .cond_true(cond_true), .flag_set(flag_set), .src1(src1), .src2(src2),
		.wb_valid(wb_valid), .wb_wr_en(wb_wr_en), .wb_data(wb_data), .flag_z(flag_z), .flag_n(flag_n), .flag_c(flag_c),
		.flag_v(flag_v), .flag_s(flag_s));
	bcd_pipe bcd_pipe_i (.aclk(aclk), .op_valid(op_valid), .op_code(op_code), .cond_true(cond_true),
		.flag_set(flag_set), .src1(src1), .src2(src2), .wb_data(wb_data));
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_f(input logic [4:0] exp);
		samples_checked++;
		if ({flag_s, flag_v, flag_c, flag_n, flag_z} !== exp) begin
			n_fail++;
			$display("[FAIL] %0t flags %b expected %b", $time, {flag_s, flag_v, flag_c, flag_n, flag_z}, exp);
		end
	endtask
	task automatic ex(input bcd_op_t op, input logic cc, input logic f, input logic [31:0] a, input logic [31:0] b,
		input logic we, input logic [31:0] ed, input logic [4:0] ef);
		bcd_pipe_i.issue(op, cc, f, a, b);
		chk({30'h0, wb_valid, wb_wr_en}, {30'h0, 1'b1, we});
		chk(wb_data, ed);
		chk_f(ef);
	endtask
	task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, ed);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask
	initial begin
		#100000;
		n_fail++;
		stop_test();
	end
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		chk_f(5'h00);
		axr(BCD_FLAGS_OFF, 32'h0, BCD_RESP_OKAY);
		axr(BCD_LAST_OFF, 32'h0, BCD_RESP_OKAY);
		axr(4'hc, 32'h0, BCD_RESP_SLVERR);
		$display("test reset done");
		ex(short_bit_test_op, 1'b1, 1'b0, 32'h8000_0000, 32'h0000_003f, 1'b0, 32'h0, 5'h02);
		ex(bit_test_op, 1'b1, 1'b0, 32'hffff_fffe, 32'h0000_0020, 1'b0, 32'h0, 5'h01);
		$display("test bit_test done");
		ex(compare_op, 1'b1, 1'b1, 32'h9, 32'h9, 1'b0, 32'h0, 5'h01);
		ex(compare_op, 1'b1, 1'b0, 32'h5, 32'h7, 1'b0, 32'h0, 5'h06);
		ex(short_compare_op, 1'b1, 1'b0, 32'h8000_0000, 32'h1, 1'b0, 32'h0, 5'h08);
		$display("test compare done");
		ex(bit_toggle_op, 1'b1, 1'b0, 32'h0000_0010, 32'h0000_0024, 1'b1, 32'h0, 5'h08);
		ex(bit_toggle_op, 1'b1, 1'b1, 32'h7fff_ffff, 32'h0000_001f, 1'b1, 32'hffff_ffff, 5'h0a);
		ex(bit_toggle_op, 1'b0, 1'b1, 32'h0, 32'h0, 1'b0, 32'hffff_ffff, 5'h0a);
		ex(compare_op, 1'b0, 1'b0, 32'h0, 32'h1, 1'b0, 32'hffff_ffff, 5'h0a);
		ex(division_step_op, 1'b0, 1'b0, 32'h5, 32'h1, 1'b0, 32'hffff_ffff, 5'h0a);
		$display("test toggle done");
		axw(BCD_FLAGS_OFF, 32'h1f, 4'hf, BCD_RESP_OKAY);
		chk_f(5'h1f);
		axw(BCD_FLAGS_OFF, 32'h0, 4'h0, BCD_RESP_OKAY);
		axw(BCD_STEP_OFF, 32'h0, 4'hf, BCD_RESP_SLVERR);
		axw(4'hc, 32'h0, 4'hf, BCD_RESP_SLVERR);
		axr(BCD_FLAGS_OFF, 32'h1f, BCD_RESP_OKAY);
		$display("test registers done");
		ex(division_step_op, 1'b1, 1'b1, 32'h0, 32'h1234_5678, 1'b1, 32'h0, 5'h1f);
		ex(division_step_op, 1'b1, 1'b0, 32'h3, 32'h5, 1'b1, 32'h1, 5'h1f);
		ex(division_step_op, 1'b1, 1'b0, 32'h1, 32'h5, 1'b1, 32'h2, 5'h1f);
		ex(compare_op, 1'b1, 1'b0, 32'h3, 32'h3, 1'b0, 32'h2, 5'h11);
		bcd_pipe_i.div_seq(16'h0001, 16'h0003);
		chk(wb_data, 32'h0001_2aaa);
		axr(BCD_STEP_OFF, 32'h0000_010f, BCD_RESP_OKAY);
		axr(BCD_LAST_OFF, 32'h0001_2aaa, BCD_RESP_OKAY);
		bcd_pipe_i.div_seq(16'h0005, 16'h0005);
		chk(wb_data & 32'h0000_7fff, 32'h0000_7fff);
		chk(wb_data, 32'h0002_ffff);
		chk_f(5'h11);
		$display("test division done");
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		chk_f(5'h00);
		chk(wb_data, 32'h0);
		axr(BCD_STEP_OFF, 32'h0, BCD_RESP_OKAY);
		axr(BCD_LAST_OFF, 32'h0, BCD_RESP_OKAY);
		$display("test second reset done");
		stop_test();
	end
endmodule
